//--- pkg/sspa_alu_regs.svh
// Constants of the saturating pack datapath: register numbers, field widths, reset values.
`ifndef SSPA_ALU_REGS_SVH
`define SSPA_ALU_REGS_SVH

// ==========================================================================
// Reserved register numbers
// ==========================================================================
`define SSPA_STACK_POINTER_REG   4'hd
`define SSPA_PROGRAM_COUNTER_REG 4'hf

// ==========================================================================
// Field layout and reset values
// ==========================================================================
`define SSPA_WORD_W      32
`define SSPA_REG_W       4
`define SSPA_SHIFT_W     5
`define SSPA_ROT_W       2
`define SSPA_Q_RESET     1'h0
`define SSPA_DATA_RESET  32'h0000_0000
`define SSPA_LATENCY     1

`endif

//--- pkg/sspa_pkg.sv
// Types of the saturating pack datapath: operation codes and request and answer carriers.
package sspa_pkg;

    typedef enum logic [4:0] {
        sat_add_sub_exchange   = 5'h00,
        sat_sub_add_exchange   = 5'h01,
        sat_double_add         = 5'h02,
        sat_double_sub         = 5'h03,
        usat_add_sub_exchange  = 5'h04,
        usat_sub_add_exchange  = 5'h05,
        usat_dual_half_add     = 5'h06,
        usat_quad_byte_add     = 5'h07,
        usat_dual_half_sub     = 5'h08,
        usat_quad_byte_sub     = 5'h09,
        pack_bottom_top        = 5'h0a,
        pack_top_bottom        = 5'h0b,
        sign_ext_byte          = 5'h0c,
        sign_ext_half          = 5'h0d,
        sign_ext_dual_byte     = 5'h0e,
        zero_ext_byte          = 5'h0f,
        zero_ext_half          = 5'h10,
        zero_ext_dual_byte     = 5'h11,
        sign_ext_byte_add      = 5'h12,
        sign_ext_half_add      = 5'h13,
        sign_ext_dual_byte_add = 5'h14,
        zero_ext_byte_add      = 5'h15,
        zero_ext_half_add      = 5'h16,
        zero_ext_dual_byte_add = 5'h17
    } sspa_op_e;

    typedef struct packed {
        logic        valid;
        sspa_op_e    op;
        logic [3:0]  rd;
        logic [3:0]  rn;
        logic [3:0]  rm;
        logic [31:0] opnd_a;
        logic [31:0] opnd_b;
        logic [4:0]  shift;
        logic [1:0]  rot;
    } sspa_req_s;

    typedef struct packed {
        logic        valid;
        logic        illegal;
        logic [3:0]  rd;
        logic [31:0] data;
    } sspa_resp_s;

endpackage : sspa_pkg

//--- verilog/sspa_alu.sv
// Saturating SIMD, pack and extend datapath slice with the sticky saturation flag.
`timescale 1ns/1ps
`include "sspa_alu_regs.svh"

// Overview of operation
// - Signed add-sub exchange, halves clamp to 16 bits.
// - Signed sub-add exchange, halves clamp to 16 bits.
// - These operations never write condition flags.
// - Double-add: saturate doubled operand, add, saturate.
// - Double-sub: saturate doubled operand, subtract, saturate.
// - Either double stage clamping sets sticky flag.
// - Unsigned add-sub exchange clamps to 0..65535.
// - Unsigned sub-add exchange clamps to 0..65535.
// - Unsigned halfword adds clamp at 65535.
// - Unsigned byte adds clamp at 255.
// - Unsigned halfword subtracts clamp at zero.
// - Unsigned byte subtracts clamp at zero.
// - Bottom-top pack: first bottom, shifted second top.
// - Bottom-top left shift 1..31, zero unshifted.
// - Top-bottom right shift 1..32, zero means 32.
// - Extend byte, halfword or two bytes.
// - Extend then add to word or lanes.
// - Only a double-form clamp sets sticky flag, q_clear clears it, else flag kept.
// - Top-bottom pack: first top, shifted second bottom.

module sspa_alu
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               sys_rst,
    // Operation request from issue
    input  wire sspa_pkg::sspa_req_s req,
    // Status word write that clears the sticky flag
    input  wire logic               q_clear,
    // Result to register file writeback
    output sspa_pkg::sspa_resp_s    resp,
    // Status word state
    output logic                    q_flag,
    output logic                    cc_write
);

    // ======================================================================
    // Operand checks
    // ======================================================================
    logic [31:0] a;
    logic [31:0] b;
    logic        legal;
    logic        take;

    assign a = req.opnd_a;
    assign b = req.opnd_b;

    function automatic logic bad_reg(input logic [3:0] r);
        bad_reg = (r == `SSPA_STACK_POINTER_REG) || (r == `SSPA_PROGRAM_COUNTER_REG);
    endfunction : bad_reg

    // A request naming a reserved register is answered but never written back.
    assign legal = !(bad_reg(req.rd) || bad_reg(req.rn) || bad_reg(req.rm));
    assign take  = req.valid && legal;

    // ======================================================================
    // Saturation helpers
    // ======================================================================
    // Each returns the clamp indication above the clamped value.
    function automatic logic [16:0] ssat16(input logic [16:0] v);
        if (v[16] != v[15])
            ssat16 = {1'b1, v[16] ? 16'h8000 : 16'h7fff};
        else
            ssat16 = {1'b0, v[15:0]};
    endfunction : ssat16

    function automatic logic [32:0] ssat32(input logic [32:0] v);
        if (v[32] != v[31])
            ssat32 = {1'b1, v[32] ? 32'h8000_0000 : 32'h7fff_ffff};
        else
            ssat32 = {1'b0, v[31:0]};
    endfunction : ssat32

    // ======================================================================
    // Signed exchange forms
    // ======================================================================
    logic [16:0] sx_hi_add;
    logic [16:0] sx_lo_sub;
    logic [16:0] sx_hi_sub;
    logic [16:0] sx_lo_add;

    assign sx_hi_add = ssat16(17'({a[31], a[31:16]} + {b[15], b[15:0]}));
    assign sx_lo_sub = ssat16(17'({a[15], a[15:0]} - {b[31], b[31:16]}));
    assign sx_hi_sub = ssat16(17'({a[31], a[31:16]} - {b[15], b[15:0]}));
    assign sx_lo_add = ssat16(17'({a[15], a[15:0]} + {b[31], b[31:16]}));

    // ======================================================================
    // Doubling forms
    // ======================================================================
    logic [32:0] dbl;
    logic [32:0] dbl_add;
    logic [32:0] dbl_sub;

    assign dbl     = ssat32({b[31], b[30:0], 1'b0});
    assign dbl_add = ssat32(33'({a[31], a} + {dbl[31], dbl[31:0]}));
    assign dbl_sub = ssat32(33'({a[31], a} - {dbl[31], dbl[31:0]}));

    // ======================================================================
    // Unsigned exchange forms
    // ======================================================================
    logic [16:0] ux_hi_add;
    logic [16:0] ux_lo_sub;
    logic [16:0] ux_hi_sub;
    logic [16:0] ux_lo_add;
    logic [31:0] ux_asx;
    logic [31:0] ux_sax;

    assign ux_hi_add = 17'({1'b0, a[31:16]} + {1'b0, b[15:0]});
    assign ux_lo_sub = 17'({1'b0, a[15:0]} - {1'b0, b[31:16]});
    assign ux_hi_sub = 17'({1'b0, a[31:16]} - {1'b0, b[15:0]});
    assign ux_lo_add = 17'({1'b0, a[15:0]} + {1'b0, b[31:16]});
    assign ux_asx = {ux_hi_add[16] ? 16'hffff : ux_hi_add[15:0],
                     ux_lo_sub[16] ? 16'h0000 : ux_lo_sub[15:0]};
    assign ux_sax = {ux_hi_sub[16] ? 16'h0000 : ux_hi_sub[15:0],
                     ux_lo_add[16] ? 16'hffff : ux_lo_add[15:0]};

    // ======================================================================
    // Unsigned lane forms
    // ======================================================================
    logic [31:0] uh_add;
    logic [31:0] uh_sub;
    logic [31:0] ub_add;
    logic [31:0] ub_sub;

    for (genvar h = 0; h < 2; h++)
    begin : g_half
        logic [16:0] s;
        logic [16:0] d;
        assign s = 17'({1'b0, a[16*h +: 16]} + {1'b0, b[16*h +: 16]});
        assign d = 17'({1'b0, a[16*h +: 16]} - {1'b0, b[16*h +: 16]});
        assign uh_add[16*h +: 16] = s[16] ? 16'hffff : s[15:0];
        assign uh_sub[16*h +: 16] = d[16] ? 16'h0000 : d[15:0];
    end

    for (genvar y = 0; y < 4; y++)
    begin : g_byte
        logic [8:0] s;
        logic [8:0] d;
        assign s = 9'({1'b0, a[8*y +: 8]} + {1'b0, b[8*y +: 8]});
        assign d = 9'({1'b0, a[8*y +: 8]} - {1'b0, b[8*y +: 8]});
        assign ub_add[8*y +: 8] = s[8] ? 8'hff : s[7:0];
        assign ub_sub[8*y +: 8] = d[8] ? 8'h00 : d[7:0];
    end

    // ======================================================================
    // Pack forms
    // ======================================================================
    logic [31:0] shl;
    logic [31:0] sar;

    // A zero shift field leaves the operand as it is.
    assign shl = b << req.shift;
    // A zero shift field stands for a full 32-bit arithmetic shift.
    assign sar = (req.shift == 5'h00) ? {32{b[31]}} : 32'($signed(b) >>> req.shift);

    // ======================================================================
    // Extend forms
    // ======================================================================
    logic [31:0] rb;
    logic [31:0] sxb;
    logic [31:0] sxh;
    logic [31:0] sxb2;
    logic [31:0] zxb;
    logic [31:0] zxh;
    logic [31:0] zxb2;

    always_comb
    begin
        unique case (req.rot)
            2'h0: rb = b;
            2'h1: rb = {b[7:0], b[31:8]};
            2'h2: rb = {b[15:0], b[31:16]};
            2'h3: rb = {b[23:0], b[31:24]};
        endcase
    end

    assign sxb  = {{24{rb[7]}}, rb[7:0]};
    assign sxh  = {{16{rb[15]}}, rb[15:0]};
    assign sxb2 = {{8{rb[23]}}, rb[23:16], {8{rb[7]}}, rb[7:0]};
    assign zxb  = {24'h00_0000, rb[7:0]};
    assign zxh  = {16'h0000, rb[15:0]};
    assign zxb2 = {8'h00, rb[23:16], 8'h00, rb[7:0]};

    function automatic logic [31:0] lane_add(input logic [31:0] x, input logic [31:0] e);
        lane_add = {16'(x[31:16] + e[31:16]), 16'(x[15:0] + e[15:0])};
    endfunction : lane_add

    // ======================================================================
    // Result select
    // ======================================================================
    logic [31:0] next_data;
    logic        next_sat;

    always_comb
    begin
        next_sat = 1'b0;
        unique case (req.op)
            sspa_pkg::sat_add_sub_exchange:   next_data = {sx_hi_add[15:0], sx_lo_sub[15:0]};
            sspa_pkg::sat_sub_add_exchange:   next_data = {sx_hi_sub[15:0], sx_lo_add[15:0]};
            sspa_pkg::sat_double_add:
            begin
                next_data = dbl_add[31:0];
                next_sat  = dbl[32] | dbl_add[32];
            end
            sspa_pkg::sat_double_sub:
            begin
                next_data = dbl_sub[31:0];
                next_sat  = dbl[32] | dbl_sub[32];
            end
            sspa_pkg::usat_add_sub_exchange:  next_data = ux_asx;
            sspa_pkg::usat_sub_add_exchange:  next_data = ux_sax;
            sspa_pkg::usat_dual_half_add:     next_data = uh_add;
            sspa_pkg::usat_quad_byte_add:     next_data = ub_add;
            sspa_pkg::usat_dual_half_sub:     next_data = uh_sub;
            sspa_pkg::usat_quad_byte_sub:     next_data = ub_sub;
            sspa_pkg::pack_bottom_top:        next_data = {shl[31:16], a[15:0]};
            sspa_pkg::pack_top_bottom:        next_data = {a[31:16], sar[15:0]};
            sspa_pkg::sign_ext_byte:          next_data = sxb;
            sspa_pkg::sign_ext_half:          next_data = sxh;
            sspa_pkg::sign_ext_dual_byte:     next_data = sxb2;
            sspa_pkg::zero_ext_byte:          next_data = zxb;
            sspa_pkg::zero_ext_half:          next_data = zxh;
            sspa_pkg::zero_ext_dual_byte:     next_data = zxb2;
            sspa_pkg::sign_ext_byte_add:      next_data = 32'(a + sxb);
            sspa_pkg::sign_ext_half_add:      next_data = 32'(a + sxh);
            sspa_pkg::sign_ext_dual_byte_add: next_data = lane_add(a, sxb2);
            sspa_pkg::zero_ext_byte_add:      next_data = 32'(a + zxb);
            sspa_pkg::zero_ext_half_add:      next_data = 32'(a + zxh);
            sspa_pkg::zero_ext_dual_byte_add: next_data = lane_add(a, zxb2);
            default:                          next_data = `SSPA_DATA_RESET;
        endcase
    end

    // ======================================================================
    // Result register
    // ======================================================================
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            resp <= '0;
        end
        else
        begin
            resp.valid   <= req.valid;
            resp.illegal <= req.valid && !legal;
            resp.rd      <= req.rd;
            resp.data    <= take ? next_data : `SSPA_DATA_RESET;
        end
    end

    // ======================================================================
    // Status word
    // ======================================================================
    // A clamp in the same cycle as a clear wins, so no saturation is lost.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            q_flag <= `SSPA_Q_RESET;
        else if (take && next_sat)
            q_flag <= 1'b1;
        else if (q_clear)
            q_flag <= 1'b0;
    end

    // None of these operations writes the arithmetic condition flags.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cc_write <= 1'b0;
        else
            cc_write <= 1'b0;
    end

    // ======================================================================
    // Checks
    // ======================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence s_take(sspa_pkg::sspa_op_e o);
        req.valid && legal && req.op == o;
    endsequence

    a_resp_latency:   assert property (req.valid |=> resp.valid) else $error("answer late");
    a_reserved_reg:   assert property (req.valid && !legal |=> resp.illegal && resp.data == 32'h0)
                          else $error("reserved register written");
    a_flags_untouched: assert property (##1 !cc_write) else $error("condition flags written");
    a_q_sticky_set:   assert property (take && next_sat |=> q_flag [*1] ##1 (q_flag || $past(q_clear)))
                          else $error("sticky flag not set");
    a_q_hold_value:   assert property (!(take && next_sat) && !q_clear |=> $stable(q_flag))
                          else $error("sticky flag moved");
    a_dbl_clamp_max:  assert property (s_take(sspa_pkg::sat_double_add) ##0 (a == 32'h7fff_ffff && !b[31])
                          |=> resp.data == 32'h7fff_ffff
                              && q_flag == (!$past(b == 32'h0) || ($past(q_flag) && !$past(q_clear))))
                          else $error("double add not clamped");
    a_pack_bt_bottom: assert property (s_take(sspa_pkg::pack_bottom_top) |=> resp.data[15:0] == $past(a[15:0]))
                          else $error("pack bottom half wrong");
    a_pack_tb_top:    assert property (s_take(sspa_pkg::pack_top_bottom) ##0 req.shift == 5'h00
                          |=> resp.data == {$past(a[31:16]), {16{$past(b[31])}}})
                          else $error("pack top half wrong");
    a_ubyte_add_floor: assert property (s_take(sspa_pkg::usat_quad_byte_add)
                          |=> resp.data[7:0] >= $past(a[7:0]) && resp.data[7:0] >= $past(b[7:0]))
                          else $error("byte add wrapped");
    a_uhalf_sub_ceil: assert property (s_take(sspa_pkg::usat_dual_half_sub) |=> resp.data[31:16] <= $past(a[31:16]))
                          else $error("halfword subtract wrapped");
    a_zext_byte_top:  assert property (s_take(sspa_pkg::zero_ext_byte) |=> resp.data[31:8] == 24'h0)
                          else $error("zero extend left high bits");

endmodule : sspa_alu

//--- tb/saturating_simd_pack_alu_tb_top.sv
// Self-checking testbench of the saturating pack datapath.
`timescale 1ns/1ps
`include "sspa_alu_regs.svh"

module saturating_simd_pack_alu_tb_top;

    // ==========================================================================
    // Signals and design instance
    // ==========================================================================
    logic                 clk;
    logic                 sys_rst;
    sspa_pkg::sspa_req_s  req;
    logic                 q_clear;
    sspa_pkg::sspa_resp_s resp;
    logic                 q_flag;
    logic                 cc_write;
    int                   n_mismatch;
    int                   n_tests;
    logic                 exp_q;
    logic                 sat_seen;

    sspa_alu sspa_alu_i
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .req      (req),
        .q_clear  (q_clear),
        .resp     (resp),
        .q_flag   (q_flag),
        .cc_write (cc_write)
    );

    always #20 clk = ~clk;

    // ==========================================================================
    // Reference arithmetic
    // ==========================================================================
    // Signed clamp; records any clamping so the sticky flag can be predicted.
    function automatic logic [31:0] ssat(input longint v, input int n);
        longint hi;
        hi = (longint'(1) <<< (n - 1)) - 1;
        sat_seen |= (v > hi) || (v < -hi - 1);
        return 32'((v > hi) ? hi : (v < -hi - 1) ? -hi - 1 : v);
    endfunction : ssat

    function automatic logic [31:0] usat(input longint v, input int n);
        longint hi;
        hi = (longint'(1) <<< n) - 1;
        return 32'((v > hi) ? hi : (v < 0) ? 0 : v);
    endfunction : usat

    function automatic logic [31:0] model(input sspa_pkg::sspa_op_e op, input logic [31:0] a,
                                          input logic [31:0] b, input logic [4:0] sh, input logic [1:0] rot);
        logic [31:0] r, e, qa, qs, pbt, ptb;
        longint      at, ab, bt, bb, ut, ub, vt, vb, sa, sb;
        at  = $signed(a[31:16]);
        ab  = $signed(a[15:0]);
        bt  = $signed(b[31:16]);
        bb  = $signed(b[15:0]);
        ut  = a[31:16];
        ub  = a[15:0];
        vt  = b[31:16];
        vb  = b[15:0];
        sa  = $signed(a);
        sb  = $signed(b);
        r   = (b >> (8 * rot)) | (b << (32 - 8 * rot));
        pbt = b << sh;
        ptb = 32'(sb >>> ((sh == 5'h00) ? 32 : sh));
        for (int i = 0; i < 4; i++)
        begin
            qa[8*i+:8] = 8'(usat(longint'(a[8*i+:8]) + longint'(b[8*i+:8]), 8));
            qs[8*i+:8] = 8'(usat(longint'(a[8*i+:8]) - longint'(b[8*i+:8]), 8));
        end
        e = 32'h0000_0000;
        case (op)
            sspa_pkg::sat_add_sub_exchange:  e = {16'(ssat(at + bb, 16)), 16'(ssat(ab - bt, 16))};
            sspa_pkg::sat_sub_add_exchange:  e = {16'(ssat(at - bb, 16)), 16'(ssat(ab + bt, 16))};
            sspa_pkg::sat_double_add:        e = ssat(sa + longint'($signed(ssat(2 * sb, 32))), 32);
            sspa_pkg::sat_double_sub:        e = ssat(sa - longint'($signed(ssat(2 * sb, 32))), 32);
            sspa_pkg::usat_add_sub_exchange: e = {16'(usat(ut + vb, 16)), 16'(usat(ub - vt, 16))};
            sspa_pkg::usat_sub_add_exchange: e = {16'(usat(ut - vb, 16)), 16'(usat(ub + vt, 16))};
            sspa_pkg::usat_dual_half_add:    e = {16'(usat(ut + vt, 16)), 16'(usat(ub + vb, 16))};
            sspa_pkg::usat_dual_half_sub:    e = {16'(usat(ut - vt, 16)), 16'(usat(ub - vb, 16))};
            sspa_pkg::usat_quad_byte_add:    e = qa;
            sspa_pkg::usat_quad_byte_sub:    e = qs;
            sspa_pkg::pack_bottom_top:       e = {pbt[31:16], a[15:0]};
            sspa_pkg::pack_top_bottom:       e = {a[31:16], ptb[15:0]};
            sspa_pkg::sign_ext_byte, sspa_pkg::sign_ext_byte_add: e = {{24{r[7]}}, r[7:0]};
            sspa_pkg::sign_ext_half, sspa_pkg::sign_ext_half_add: e = {{16{r[15]}}, r[15:0]};
            sspa_pkg::zero_ext_byte, sspa_pkg::zero_ext_byte_add: e = {24'h0, r[7:0]};
            sspa_pkg::zero_ext_half, sspa_pkg::zero_ext_half_add: e = {16'h0, r[15:0]};
            sspa_pkg::sign_ext_dual_byte, sspa_pkg::sign_ext_dual_byte_add:
                e = {{8{r[23]}}, r[23:16], {8{r[7]}}, r[7:0]};
            sspa_pkg::zero_ext_dual_byte, sspa_pkg::zero_ext_dual_byte_add: e = {8'h0, r[23:16], 8'h0, r[7:0]};
            default:                         e = 32'h0000_0000;
        endcase
        if (op inside {sspa_pkg::sign_ext_byte_add, sspa_pkg::sign_ext_half_add,
                       sspa_pkg::zero_ext_byte_add, sspa_pkg::zero_ext_half_add})
            e = a + e;
        if (op inside {sspa_pkg::sign_ext_dual_byte_add, sspa_pkg::zero_ext_dual_byte_add})
            e = {a[31:16] + e[31:16], a[15:0] + e[15:0]};
        return e;
    endfunction : model

    // ==========================================================================
    // Drivers and comparison
    // ==========================================================================
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Holds the request up after the answer, so consecutive calls run back to back.
    task automatic run(input sspa_pkg::sspa_op_e op, input logic [31:0] a, input logic [31:0] b,
                       input logic [4:0] sh, input logic [1:0] rot, input logic [11:0] regs = 12'h321,
                       input logic clr = 1'b0);
        logic [31:0] e;
        logic        bad;
        sat_seen = 1'b0;
        e        = model(op, a, b, sh, rot);
        bad      = 1'b0;
        for (int i = 0; i < 3; i++)
            bad |= regs[4*i+:4] inside {`SSPA_STACK_POINTER_REG, `SSPA_PROGRAM_COUNTER_REG};
        req     = '{valid: 1'b1, op: op, rd: regs[11:8], rn: regs[7:4], rm: regs[3:0],
                    opnd_a: a, opnd_b: b, shift: sh, rot: rot};
        q_clear = clr;
        if (!bad && sat_seen && (op inside {sspa_pkg::sat_double_add, sspa_pkg::sat_double_sub}))
            exp_q = 1'b1;
        else if (clr)
            exp_q = 1'b0;
        @(posedge clk);
        #1;
        chk("resp_valid", 32'h1, 32'(resp.valid));
        chk("resp_illegal", 32'(bad), 32'(resp.illegal));
        chk("resp_rd", 32'(regs[11:8]), 32'(resp.rd));
        chk("resp_data", bad ? 32'h0 : e, resp.data);
        chk("q_flag", 32'(exp_q), 32'(q_flag));
        chk("cc_write", 32'h0, 32'(cc_write));
    endtask : run

    task automatic idle(input logic clr);
        req.valid = 1'b0;
        q_clear   = clr;
        if (clr)
            exp_q = 1'b0;
        @(posedge clk);
        #1;
        chk("idle_valid", 32'h0, 32'(resp.valid));
        chk("idle_data", 32'h0, resp.data);
        chk("q_flag", 32'(exp_q), 32'(q_flag));
    endtask : idle

    // ==========================================================================
    // Scenarios
    // ==========================================================================
    task automatic t_signed_exchange;
        run(sspa_pkg::sat_add_sub_exchange, 32'h7fff_8000, 32'h0001_0001, 5'h00, 2'h0);
        run(sspa_pkg::sat_sub_add_exchange, 32'h7fff_8000, 32'h0001_0001, 5'h00, 2'h0);
        run(sspa_pkg::sat_add_sub_exchange, 32'h1234_0010, 32'h0020_0005, 5'h00, 2'h0);
        run(sspa_pkg::sat_sub_add_exchange, 32'h8000_7fff, 32'h0001_0001, 5'h00, 2'h0);
        idle(1'b0);
    endtask : t_signed_exchange

    task automatic t_double;
        run(sspa_pkg::sat_double_add, 32'h0000_0010, 32'h0000_0004, 5'h00, 2'h0);
        run(sspa_pkg::sat_double_add, 32'h0000_0000, 32'h4000_0000, 5'h00, 2'h0);
        idle(1'b1);
        run(sspa_pkg::sat_double_add, 32'h7fff_ffff, 32'h0000_0001, 5'h00, 2'h0);
        run(sspa_pkg::sat_double_sub, 32'h0000_0000, 32'hc000_0000, 5'h00, 2'h0, 12'h321, 1'b1);
        idle(1'b1);
        run(sspa_pkg::sat_double_sub, 32'h8000_0000, 32'h0000_0001, 5'h00, 2'h0);
        run(sspa_pkg::sat_double_sub, 32'h0000_1000, 32'h0000_0003, 5'h00, 2'h0);
        idle(1'b1);
    endtask : t_double

    task automatic t_unsigned;
        for (int i = 4; i <= 9; i++)
        begin
            run(sspa_pkg::sspa_op_e'(5'(i)), 32'hffff_0003, 32'h0002_fff0, 5'h00, 2'h0);
            run(sspa_pkg::sspa_op_e'(5'(i)), 32'h80fe_017f, 32'h8003_02ff, 5'h00, 2'h0);
        end
        idle(1'b0);
    endtask : t_unsigned

    task automatic t_pack;
        int shs[5] = '{0, 1, 15, 16, 31};
        for (int k = 0; k < 5; k++)
        begin
            run(sspa_pkg::pack_bottom_top, 32'h1234_abcd, 32'h8765_4321, 5'(shs[k]), 2'h0);
            run(sspa_pkg::pack_top_bottom, 32'h1234_abcd, 32'h8765_4321, 5'(shs[k]), 2'h0);
            run(sspa_pkg::pack_top_bottom, 32'h1234_abcd, 32'h7765_4321, 5'(shs[k]), 2'h0);
        end
        idle(1'b0);
    endtask : t_pack

    task automatic t_extend;
        for (int i = 12; i <= 23; i++)
            for (int k = 0; k < 4; k++)
                run(sspa_pkg::sspa_op_e'(5'(i)), 32'h1234_fedc, 32'h80f1_7f02, 5'h00, 2'(k));
        idle(1'b0);
    endtask : t_extend

    task automatic t_illegal;
        run(sspa_pkg::sat_double_add, 32'h7fff_ffff, 32'h0000_0001, 5'h00, 2'h0, 12'hd12);
        run(sspa_pkg::sat_double_sub, 32'h8000_0000, 32'h0000_0001, 5'h00, 2'h0, 12'h1f2);
        run(sspa_pkg::sat_add_sub_exchange, 32'h7fff_0000, 32'h0001_0000, 5'h00, 2'h0, 12'h12d);
        run(sspa_pkg::usat_quad_byte_add, 32'hffff_ffff, 32'h0101_0101, 5'h00, 2'h0, 12'he0c);
        // An operation code beyond the last defined one answers with a zero result.
        run(sspa_pkg::sspa_op_e'(5'h18), 32'h1234_5678, 32'h0000_0001, 5'h00, 2'h0);
        idle(1'b0);
    endtask : t_illegal

    // ==========================================================================
    // Run control
    // ==========================================================================
    task automatic test_done;
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    initial
    begin
        #(40 * 2000);
        n_mismatch++;
        test_done();
    end

    initial
    begin
        clk        = 1'b0;
        sys_rst    = 1'b1;
        req        = '0;
        q_clear    = 1'b0;
        exp_q      = 1'b0;
        sat_seen   = 1'b0;
        n_mismatch = 0;
        n_tests    = 0;
        repeat (4) @(posedge clk);
        #1;
        chk("reset_resp", 32'h0, resp.data);
        chk("reset_resp_ctl", 32'h0, 32'({resp.valid, resp.illegal, resp.rd}));
        chk("reset_q_flag", 32'h0, 32'(q_flag));
        chk("reset_cc_write", 32'h0, 32'(cc_write));
        sys_rst = 1'b0;
        idle(1'b0);
        t_signed_exchange();
        t_double();
        t_unsigned();
        t_pack();
        t_extend();
        t_illegal();
        test_done();
    end

endmodule : saturating_simd_pack_alu_tb_top
